// *** logic/tfr_defs.svh ***
// constants of the temperature fault response block
// Summary of operation
// - die overtemp sets other-fault summary, vendor word bit and vendor-status overtemp bit.
// - every temperature fault drives the alert line unless its source is masked.
// - die action response codes 00 and 01 are unsupported; writing them raises comm fault.
// - die response 10 disables the output at once, then follows the retry field.
// - die response 11 holds output off only while the condition lasts, then resumes.
// - latched fault bits clear only by clear-faults, off-then-on, or bias reapplied.
// - retry 000 means no restart; output stays off until the fault is cleared.
// - die action retry values 001 to 111 are rejected and raise comm fault.
// - die action delay bits 2:0 are ignored whatever they hold.
// - external overtemp action at 0x50, paged, read/write, default 0xb8.
// - external undertemp action at 0x54, paged, read/write, default 0xb8.
// - external overtemp sets temperature summary bit and temperature-status overtemp bit.
// - external undertemp sets temperature summary bit and temperature-status undertemp bit.
// - external faults come from converter results, so response lags one conversion.
// - each external action command carries exactly one data byte.
// - die action at 0xd6, read-only, shared by both channels, default 0xc0.
// - external response 00 keeps operating after the fault is flagged.
// - external retry 111 restarts continuously, spaced by the retry delay.
`ifndef TFR_DEFS_SVH
`define TFR_DEFS_SVH

`define TFR_CMD_EXT_OT     8'h50
`define TFR_CMD_EXT_UT     8'h54
`define TFR_CMD_DIE_OT     8'hd6
`define TFR_CMD_STAT_BYTE  8'h78
`define TFR_CMD_STAT_WORD  8'h79
`define TFR_CMD_STAT_TEMP  8'h7d
`define TFR_CMD_STAT_VEND  8'h80

`define TFR_EXT_ACT_RST    8'hb8
`define TFR_DIE_ACT_RST    8'hc0

`define TFR_RESP_HI        7
`define TFR_RESP_LO        6
`define TFR_RETRY_HI       5
`define TFR_RETRY_LO       3

`define TFR_RESP_GO        2'h0
`define TFR_RESP_BAD       2'h1
`define TFR_RESP_SHUT      2'h2
`define TFR_RESP_HOLD      2'h3
`define TFR_RETRY_NONE     3'h0
`define TFR_RETRY_LOOP     3'h7

`define TFR_SB_OTHER       0
`define TFR_SB_COMM        1
`define TFR_SB_TEMP        2
`define TFR_SW_VEND        12
`define TFR_ST_OT          7
`define TFR_ST_UT          4
`define TFR_SV_OT          6

`define TFR_MSK_DIE        0
`define TFR_MSK_OT         1
`define TFR_MSK_UT         2
`define TFR_MSK_COMM       3

`endif

// *** logic/tfr_pkg.sv ***
// types of the temperature fault response block
package tfr_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       page;
        logic [7:0] code;
        logic [7:0] data;
    } tfr_cmd_type;

    typedef struct packed {
        logic       done;
        logic [1:0] ot;
        logic [1:0] ut;
    } tfr_adc_type;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_ON   = 3'b010,
        ST_SHUT = 3'b100
    } tfr_chan_type;

endpackage

// *** logic/tfr_sync.sv ***
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tfr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                meta_r[i] <= 1'b0;
                dout[i]   <= 1'b0;
            end else begin
                meta_r[i] <= din[i];
                dout[i]   <= meta_r[i];
            end
        end
    end
endmodule // tfr_sync

// *** logic/tfr_fault_resp.sv ***
// temperature fault response: action bytes, status bits, alert and channel enables
`timescale 1ns/1ps
`include "tfr_defs.svh"
module tfr_fault_resp
    import tfr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire tfr_cmd_type       cmd,
    input  wire tfr_adc_type       adc,
    input  wire logic              dieHot,
    input  wire logic [1:0]        runPin,
    input  wire logic [1:0]        opOn,
    input  wire logic              clearFaults,
    input  wire logic              retryGo,
    input  wire logic [3:0]        alertMask,
    output logic      [15:0]       rdData,
    output logic                   rdValid,
    output logic      [1:0]        chanEn,
    output logic                   alertOe
);
    logic [2:0]   syncOut;
    logic         dieSync;
    logic [1:0]   runSync;
    logic [1:0]   onReq;
    logic [1:0]   onRise;
    logic         dieRise;
    logic         dieFall;

    tfr_chan_type state_r [2];
    tfr_chan_type state_nxt [2];
    logic [7:0]   otAct_r [2];
    logic [7:0]   otAct_nxt [2];
    logic [7:0]   utAct_r [2];
    logic [7:0]   utAct_nxt [2];
    logic [1:0]   dieBit_r, dieBit_nxt;
    logic [1:0]   otBit_r, otBit_nxt;
    logic [1:0]   utBit_r, utBit_nxt;
    logic [1:0]   otCond_r, otCond_nxt;
    logic [1:0]   utCond_r, utCond_nxt;
    logic [1:0]   shutRetry_r, shutRetry_nxt;
    logic [1:0]   onReq_r;
    logic         dieSeen_r;
    logic         commFault_r, commFault_nxt;
    logic [1:0]   chanEn_r, chanEn_nxt;
    logic         alertOe_r, alertOe_nxt;
    logic [15:0]  rdData_r, rdData_nxt;
    logic         rdValid_r, rdValid_nxt;
    logic [3:0]   srcVec;
    logic [7:0]   dieAct;

    // the die action byte is fixed; it never needs a flip-flop
    assign dieAct = `TFR_DIE_ACT_RST;

    tfr_sync #(.W(3)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({runPin, dieHot}),
        .dout   (syncOut)
    );

    assign dieSync = syncOut[0];
    assign runSync = syncOut[2:1];
    assign onReq   = runSync & opOn;
    assign onRise  = onReq & ~onReq_r;
    assign dieRise = dieSync & ~dieSeen_r;
    assign dieFall = ~dieSync & dieSeen_r;
    assign srcVec  = {commFault_r, |utBit_r, |otBit_r, |dieBit_r};

    function automatic logic [1:0] resp_of(input logic [7:0] act);
        resp_of = act[`TFR_RESP_HI:`TFR_RESP_LO];
    endfunction

    function automatic logic [2:0] retry_of(input logic [7:0] act);
        retry_of = act[`TFR_RETRY_HI:`TFR_RETRY_LO];
    endfunction

    // external action byte accepts responses 00 and 10 only
    function automatic logic ext_ok(input logic [7:0] act);
        ext_ok = (resp_of(act) == `TFR_RESP_GO) || (resp_of(act) == `TFR_RESP_SHUT);
    endfunction

    // die action byte: response 1x, retry 000, delay bits don't care
    function automatic logic die_ok(input logic [7:0] act);
        die_ok = act[`TFR_RESP_HI] && (retry_of(act) == `TFR_RETRY_NONE);
    endfunction

    function automatic logic [7:0] stat_byte(input logic ch, input logic [1:0] d, input logic [1:0] o,
                                             input logic [1:0] u, input logic c);
        stat_byte = 8'h00;
        stat_byte[`TFR_SB_OTHER] = d[ch] | c;
        stat_byte[`TFR_SB_COMM]  = c;
        stat_byte[`TFR_SB_TEMP]  = o[ch] | u[ch];
    endfunction

    always_comb begin
        logic wrEn;
        logic dieShut;
        logic extShut;
        logic extRetry;
        wrEn          = cmd.valid & cmd.write;
        commFault_nxt = commFault_r;
        dieBit_nxt    = dieBit_r;
        otBit_nxt     = otBit_r;
        utBit_nxt     = utBit_r;
        otCond_nxt    = otCond_r;
        utCond_nxt    = utCond_r;
        shutRetry_nxt = shutRetry_r;
        chanEn_nxt    = 2'b00;
        dieShut       = 1'b0;
        extShut       = 1'b0;
        extRetry      = 1'b0;
        if (clearFaults) begin
            commFault_nxt = 1'b0;
        end
        // one data byte per transfer: the command port carries a single byte
        if (wrEn && cmd.code == `TFR_CMD_DIE_OT && !die_ok(cmd.data)) begin
            commFault_nxt = 1'b1;
        end
        for (int ch = 0; ch < 2; ch++) begin
            otAct_nxt[ch] = otAct_r[ch];
            utAct_nxt[ch] = utAct_r[ch];
            state_nxt[ch] = state_r[ch];
            if (wrEn && cmd.page == ch[0] && cmd.code == `TFR_CMD_EXT_OT) begin
                if (ext_ok(cmd.data)) begin
                    otAct_nxt[ch] = cmd.data;
                end else begin
                    commFault_nxt = 1'b1;
                end
            end
            if (wrEn && cmd.page == ch[0] && cmd.code == `TFR_CMD_EXT_UT) begin
                if (ext_ok(cmd.data)) begin
                    utAct_nxt[ch] = cmd.data;
                end else begin
                    commFault_nxt = 1'b1;
                end
            end
            // clears first so that a fault in the same cycle still wins
            if (clearFaults || onRise[ch]) begin
                dieBit_nxt[ch] = 1'b0;
                otBit_nxt[ch]  = 1'b0;
                utBit_nxt[ch]  = 1'b0;
            end
            if (dieRise) begin
                dieBit_nxt[ch] = 1'b1;
            end
            // converter results are the only source, hence up to one conversion of lag
            if (adc.done) begin
                otCond_nxt[ch] = adc.ot[ch];
                utCond_nxt[ch] = adc.ut[ch];
                if (adc.ot[ch]) begin
                    otBit_nxt[ch] = 1'b1;
                end
                if (adc.ut[ch]) begin
                    utBit_nxt[ch] = 1'b1;
                end
            end
            dieShut  = dieRise && resp_of(dieAct) == `TFR_RESP_SHUT;
            extShut  = adc.done && ((adc.ot[ch] && resp_of(otAct_r[ch]) == `TFR_RESP_SHUT) ||
                                    (adc.ut[ch] && resp_of(utAct_r[ch]) == `TFR_RESP_SHUT));
            extRetry = (adc.ot[ch] && retry_of(otAct_r[ch]) == `TFR_RETRY_LOOP) ||
                       (adc.ut[ch] && retry_of(utAct_r[ch]) == `TFR_RETRY_LOOP);
            unique case (state_r[ch])
                ST_OFF: begin
                    if (onReq[ch]) begin
                        state_nxt[ch] = ST_ON;
                    end
                end
                ST_ON: begin
                    if (!onReq[ch]) begin
                        state_nxt[ch] = ST_OFF;
                    end else if (dieShut || extShut) begin
                        state_nxt[ch]     = ST_SHUT;
                        shutRetry_nxt[ch] = extShut && !dieShut && extRetry;
                    end
                end
                ST_SHUT: begin
                    if (!onReq[ch]) begin
                        state_nxt[ch] = ST_OFF;
                    end else if (clearFaults) begin
                        state_nxt[ch] = ST_ON;
                    end else if (shutRetry_r[ch] && retryGo && !otCond_r[ch] && !utCond_r[ch]) begin
                        state_nxt[ch] = ST_ON;
                    end
                end
                default: begin
                    state_nxt[ch] = ST_OFF;
                end
            endcase
            // hold mode masks the enable only while the die is hot
            chanEn_nxt[ch] = (state_nxt[ch] == ST_ON) &&
                             !(dieSync && resp_of(dieAct) == `TFR_RESP_HOLD);
        end
        alertOe_nxt = |(srcVec & ~alertMask);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int ch = 0; ch < 2; ch++) begin
                state_r[ch] <= ST_OFF;
                otAct_r[ch] <= `TFR_EXT_ACT_RST;
                utAct_r[ch] <= `TFR_EXT_ACT_RST;
            end
            dieBit_r    <= 2'b00;
            otBit_r     <= 2'b00;
            utBit_r     <= 2'b00;
            otCond_r    <= 2'b00;
            utCond_r    <= 2'b00;
            shutRetry_r <= 2'b00;
            onReq_r     <= 2'b00;
            dieSeen_r   <= 1'b0;
            commFault_r <= 1'b0;
            chanEn_r    <= 2'b00;
            alertOe_r   <= 1'b0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                state_r[ch] <= state_nxt[ch];
                otAct_r[ch] <= otAct_nxt[ch];
                utAct_r[ch] <= utAct_nxt[ch];
            end
            dieBit_r    <= dieBit_nxt;
            otBit_r     <= otBit_nxt;
            utBit_r     <= utBit_nxt;
            otCond_r    <= otCond_nxt;
            utCond_r    <= utCond_nxt;
            shutRetry_r <= shutRetry_nxt;
            onReq_r     <= onReq;
            dieSeen_r   <= dieSync;
            commFault_r <= commFault_nxt;
            chanEn_r    <= chanEn_nxt;
            alertOe_r   <= alertOe_nxt;
        end
    end

    // read path
    always_comb begin
        logic p;
        p           = cmd.page;
        rdValid_nxt = cmd.valid && !cmd.write;
        rdData_nxt  = 16'h0000;
        unique case (cmd.code)
            `TFR_CMD_EXT_OT:    rdData_nxt[7:0] = otAct_r[p];
            `TFR_CMD_EXT_UT:    rdData_nxt[7:0] = utAct_r[p];
            `TFR_CMD_DIE_OT:    rdData_nxt[7:0] = dieAct;
            `TFR_CMD_STAT_BYTE: rdData_nxt[7:0] = stat_byte(p, dieBit_r, otBit_r, utBit_r, commFault_r);
            `TFR_CMD_STAT_WORD: begin
                rdData_nxt[7:0]          = stat_byte(p, dieBit_r, otBit_r, utBit_r, commFault_r);
                rdData_nxt[`TFR_SW_VEND] = dieBit_r[p];
            end
            `TFR_CMD_STAT_TEMP: begin
                rdData_nxt[`TFR_ST_OT] = otBit_r[p];
                rdData_nxt[`TFR_ST_UT] = utBit_r[p];
            end
            `TFR_CMD_STAT_VEND: rdData_nxt[`TFR_SV_OT] = dieBit_r[p];
            default:            rdData_nxt = 16'h0000;
        endcase
        if (!rdValid_nxt) begin
            rdData_nxt = rdData_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r  <= 16'h0000;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r  <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign rdData  = rdData_r;
    assign rdValid = rdValid_r;
    assign chanEn  = chanEn_r;
    assign alertOe = alertOe_r;

    a_die_status_set: assert property (@(posedge clk) disable iff (!resetn)
        dieRise |=> dieBit_r == 2'b11)
        else $error("die overtemp did not latch status");

    a_alert_follows: assert property (@(posedge clk) disable iff (!resetn)
        ##1 alertOe_r == $past(|(srcVec & ~alertMask)))
        else $error("alert does not follow unmasked faults");

    a_bad_die_comm: assert property (@(posedge clk) disable iff (!resetn)
        (cmd.valid && cmd.write && cmd.code == `TFR_CMD_DIE_OT && !cmd.data[7]) |=> commFault_r)
        else $error("unsupported die response did not raise comm fault");

    a_bad_retry_comm: assert property (@(posedge clk) disable iff (!resetn)
        (cmd.valid && cmd.write && cmd.code == `TFR_CMD_DIE_OT && cmd.data[5:3] != 3'h0) |=> commFault_r)
        else $error("unsupported die retry did not raise comm fault");

    a_ext_shut_now: assert property (@(posedge clk) disable iff (!resetn)
        (state_r[0] == ST_ON && onReq[0] && adc.done && adc.ot[0] && otAct_r[0][7:6] == 2'h2)
        |=> (state_r[0] == ST_SHUT && !chanEn_r[0]))
        else $error("shut response did not disable output");

    a_hold_resume: assert property (@(posedge clk) disable iff (!resetn)
        (dieFall && state_r[0] == ST_ON && onReq[0] && !adc.done) |=> chanEn_r[0])
        else $error("output not re-enabled after die cooled");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (otBit_r[0] && !clearFaults && !onRise[0]) |=> otBit_r[0])
        else $error("overtemp flag cleared without cause");

    a_no_restart: assert property (@(posedge clk) disable iff (!resetn)
        (state_r[0] == ST_SHUT && !shutRetry_r[0] && !clearFaults && onReq[0]) |=> state_r[0] == ST_SHUT)
        else $error("output restarted with retry disabled");

    a_ext_ut_flag: assert property (@(posedge clk) disable iff (!resetn)
        (adc.done && adc.ut[1]) |=> utBit_r[1])
        else $error("undertemp flag not set");

    a_reject_write: assert property (@(posedge clk) disable iff (!resetn)
        (cmd.valid && cmd.write && !cmd.page && cmd.code == `TFR_CMD_EXT_OT && cmd.data[6])
        |=> (otAct_r[0] == $past(otAct_r[0]) && commFault_r))
        else $error("unsupported action byte was stored");
endmodule // tfr_fault_resp

// *** tb/tfr_host_model.sv ***
// host model that drives the command port of the temperature fault response block
`timescale 1ns/1ps
module tfr_host_model
    import tfr_pkg::*;
(
    input  wire logic   clk,
    output tfr_cmd_type cmd
);
    logic [15:0] expQ[$];

    initial begin
        cmd = '0;
    end

    // one byte per command; idle fields show the inverse so stale values never look valid
    task automatic send(input logic w, input logic pg, input logic [7:0] code, input logic [7:0] data);
        cmd = {1'b1, w, pg, code, data};
        @(posedge clk);
        #1;
        cmd = {1'b0, ~w, ~pg, ~code, ~data};
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic pg, input logic [7:0] code, input logic [7:0] data);
        send(1'b1, pg, code, data);
    endtask

    task automatic rd(input logic pg, input logic [7:0] code, input logic [15:0] exp);
        expQ.push_back(exp);
        send(1'b0, pg, code, ~exp[7:0]);
    endtask
endmodule // tfr_host_model

// *** tb/test_temperature_fault_response.sv ***
// self-checking bench of the temperature fault response block
`timescale 1ns/1ps
module test_temperature_fault_response
    import tfr_pkg::*;
;
    logic        clk;
    logic        resetn;
    tfr_cmd_type cmd;
    tfr_adc_type adc;
    logic        dieHot;
    logic [1:0]  runPin;
    logic [1:0]  opOn;
    logic        clearFaults;
    logic        retryGo;
    logic [3:0]  alertMask;
    logic [15:0] rdData;
    logic        rdValid;
    logic [1:0]  chanEn;
    logic        alertOe;
    logic [31:0] seed;
    int          n_mismatch;
    int          n_checks;

    tfr_host_model host (.clk(clk), .cmd(cmd));

    tfr_fault_resp u_tfr_fault_resp (
        .clk(clk), .resetn(resetn), .cmd(cmd), .adc(adc), .dieHot(dieHot), .runPin(runPin),
        .opOn(opOn), .clearFaults(clearFaults), .retryGo(retryGo), .alertMask(alertMask),
        .rdData(rdData), .rdValid(rdValid), .chanEn(chanEn), .alertOe(alertOe)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic wrap_up;
        if (host.expQ.size() != 0) n_mismatch++;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmpRd(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpPin(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t enables and alert %b expected %b", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // bounded wait: synchroniser and state add a few edges of latency
    task automatic waitPins(input logic [1:0] en, input logic al);
        for (int i = 0; i < 8 && !(chanEn === en && alertOe === al); i++) idle(1);
        cmpPin({chanEn, alertOe}, {en, al});
    endtask

    // result fields are random outside the done pulse, since they are only valid with it
    task automatic adcPulse(input logic [1:0] ot, input logic [1:0] ut);
        adc = {1'b1, ot, ut};
        idle(1);
        adc = {1'b0, 4'($random(seed))};
        idle(1);
    endtask

    task automatic strobe(input logic clr, input logic rty);
        clearFaults = clr;
        retryGo = rty;
        idle(1);
        clearFaults = 1'b0;
        retryGo = 1'b0;
        idle(1);
    endtask

    always @(negedge clk) begin
        if (rdValid === 1'b1) begin
            if (host.expQ.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH %0t read answer without request", $time);
            end else begin
                cmpRd(rdData, host.expQ.pop_front());
            end
        end
    end

    // a full run needs well under a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        logic [7:0] d;
        seed = 32'h92c27acc;
        n_mismatch = 0;
        n_checks = 0;
        resetn = 1'b0;
        adc = '0;
        dieHot = 1'b0;
        runPin = 2'b00;
        opOn = 2'b00;
        clearFaults = 1'b0;
        retryGo = 1'b0;
        alertMask = 4'h0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        idle(1);
        for (int p = 0; p < 2; p++) begin
            host.rd(p[0], 8'h50, 16'h00b8);
            host.rd(p[0], 8'h54, 16'h00b8);
            host.rd(p[0], 8'hd6, 16'h00c0);
        end
        runPin = 2'b11;
        opOn = 2'b11;
        waitPins(2'b11, 1'b0);
        // shut without retry on channel 0
        host.wr(1'b0, 8'h50, 8'h80);
        host.rd(1'b0, 8'h50, 16'h0080);
        adcPulse(2'b01, 2'b00);
        waitPins(2'b10, 1'b1);
        host.rd(1'b0, 8'h78, 16'h0004);
        host.rd(1'b0, 8'h7d, 16'h0080);
        host.rd(1'b1, 8'h7d, 16'h0000);
        adcPulse(2'b00, 2'b00);
        strobe(1'b0, 1'b1);
        idle(2);
        cmpPin({chanEn, alertOe}, 3'b101);
        host.rd(1'b0, 8'h7d, 16'h0080);
        strobe(1'b1, 1'b0);
        waitPins(2'b11, 1'b0);
        host.rd(1'b0, 8'h78, 16'h0000);
        // continuous retry, blocked while the condition lasts
        host.wr(1'b0, 8'h50, 8'hb8);
        adcPulse(2'b01, 2'b00);
        waitPins(2'b10, 1'b1);
        strobe(1'b0, 1'b1);
        idle(2);
        cmpPin({chanEn, alertOe}, 3'b101);
        adcPulse(2'b00, 2'b00);
        strobe(1'b0, 1'b1);
        waitPins(2'b11, 1'b1);
        strobe(1'b1, 1'b0);
        waitPins(2'b11, 1'b0);
        // flag only, masked alert, then off-then-on
        alertMask = 4'b0100;
        host.wr(1'b1, 8'h54, 8'h00);
        adcPulse(2'b00, 2'b10);
        idle(3);
        cmpPin({chanEn, alertOe}, 3'b110);
        host.rd(1'b1, 8'h7d, 16'h0010);
        host.rd(1'b1, 8'h78, 16'h0004);
        alertMask = 4'b0000;
        waitPins(2'b11, 1'b1);
        opOn = 2'b01;
        idle(4);
        cmpPin({chanEn, alertOe}, 3'b011);
        opOn = 2'b11;
        waitPins(2'b11, 1'b0);
        host.rd(1'b1, 8'h7d, 16'h0000);
        // refused responses on the external byte
        for (int r = 1; r < 4; r += 2) begin
            host.wr(r[1], (r == 1) ? 8'h50 : 8'h54, {2'(r), 6'($random(seed))});
            host.rd(r[1], (r == 1) ? 8'h50 : 8'h54, (r == 1) ? 16'h00b8 : 16'h0000);
            host.rd(r[1], 8'h78, 16'h0003);
            strobe(1'b1, 1'b0);
        end
        // die byte: bad responses, bad retries, then a legal value with random delay bits
        for (int i = 0; i < 10; i++) begin
            d = (i < 2) ? 8'(i << 6) : (i < 9) ? 8'(8'hc0 | ((i - 1) << 3)) : 8'(8'hc0 | ($random(seed) & 7));
            host.wr(i[0], 8'hd6, d);
            host.rd(i[0], 8'hd6, 16'h00c0);
            host.rd(i[0], 8'h78, (i < 9) ? 16'h0003 : 16'h0000);
            strobe(1'b1, 1'b0);
        end
        // die overtemperature holds both outputs off only while hot
        dieHot = 1'b1;
        waitPins(2'b00, 1'b1);
        host.rd(1'b0, 8'h79, 16'h1001);
        host.rd(1'b1, 8'h80, 16'h0040);
        host.rd(1'b1, 8'h78, 16'h0001);
        dieHot = 1'b0;
        waitPins(2'b11, 1'b1);
        strobe(1'b1, 1'b0);
        waitPins(2'b11, 1'b0);
        idle(2);
        wrap_up();
    end
endmodule // test_temperature_fault_response
